// File: core/lnb_regs_defs.vh
// Constants for the regulator two-wire register interface
`ifndef LNB_REGS_DEFS_VH
`define LNB_REGS_DEFS_VH
// Register selector codes, top three bits of a written byte
`define SEL_FAULT_STATUS 3'h0
`define SEL_TONE_SETUP 3'h1
`define SEL_LIMIT_CMD 3'h2
`define SEL_OUTPUT_CTRL 3'h3
// Fixed upper five bits of the target address
`define ADDR_FIXED 5'h02
// Writable field masks of the low five bits
`define MASK_TONE 5'h1C
`define MASK_CMD 5'h1B
`define MASK_CTRL 5'h13
// Field positions
`define BIT_TONE_ENABLE 4
`define BIT_MOD_SELECT 3
`define BIT_TONE_THRESH 2
`define BIT_LIMIT_STATIC 4
`define BIT_VPIN_ENABLE 3
`define BIT_OUT_ENABLE 4
// Reset value of every system register
`define REG_RESET 8'h00
// Bus rates and the system clock
`define BUS_FAST_KBPS 400
`define BUS_STD_KBPS 100
`define SYS_CLK_MHZ 20
`endif

// File: core/lnb_regulator_i2c_registers.v
// Two-wire target interface and system registers of an antenna regulator
//
// Summary of operation
// - Both lines open drain; idle high; up to 400 kbit/s.
// - Data changes only while clock is low; one clock per bit.
// - Data falling with clock high starts; rising with clock high stops.
// - Bytes are eight bits MSB first, each acknowledged; count unlimited.
// - Host releases data at acknowledge; receiver holds it low throughout.
// - Addressed device acknowledges each byte; otherwise host may stop.
// - No acknowledge at all while power-good is low.
// - First byte: address 00010, two pin bits, then direction bit.
// - Written byte top three bits select status, tone, command, control.
// - Every system register bit clears to zero at power-on.
// - Overload flag reads the overload condition input.
// - Back-current flag reads the back-current protection input.
// - Voltage-range flag reads one when input or output out of range.
// - Open-cable flag reads one when output current below 2 mA.
// - Over-temperature flag reads one above 150 C, zero at 130 C.
// - Tone enable and modulation select choose the tone source.
// - Tone threshold bit picks receive or transmit detector threshold.
// - Two current-select bits set the overload threshold level.
// - Limit mode bit: zero dynamic limiting, one static limiting.
// - Voltage pin enable zero lets range pin choose; one uses bits.
// - Range and adjust bits set output level; enable off kills stages.
// - Read shifts register byte MSB first; host ack continues, nack ends.
// - Two address pins form the two low address bits.
// - While power-good is low ignore bus, hold tone, command and control registers at zero.
`timescale 1ns/1ps
`include "lnb_regs_defs.vh"
module lnb_regulator_i2c_registers (
	input wire clk_sys,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_ff,
	output reg sda_oe_ff,
	input wire power_good,
	input wire addr_pin_hi,
	input wire addr_pin_lo,
	input wire range_select_pin,
	input wire external_modulation_pin,
	input wire transmit_threshold_pin,
	input wire over_temp_in,
	input wire open_cable_in,
	input wire voltage_range_in,
	input wire overload_in,
	input wire back_current_in,
	output reg tone_on_ff,
	output reg tone_passthru_ff,
	output reg tone_threshold_ff,
	output reg limit_mode_static_ff,
	output reg [1:0] current_level_ff,
	output reg output_enable_ff,
	output reg [1:0] voltage_level_ff,
	output reg [7:0] fault_status_ff
);
	// ******************************
	// State codes
	// ******************************
	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_WDATA = 3'd2;
	localparam ST_ACK = 3'd3;
	localparam ST_RDATA = 3'd4;
	localparam ST_RACK = 3'd5;
	localparam ST_IGNORE = 3'd6;

	// ******************************
	// Input synchronisers
	// ******************************
	wire scl_s;
	wire sda_s;
	wire pg_s;
	wire th_s;
	wire rsel_s;
	wire external_modulation_pin_s;
	wire [4:0] flt_s;

	sync_two_ff u_scl (.clk_sys(clk_sys), .rst(rst), .async_in(scl_in),
		.rst_val(1'b1), .sync_ff(scl_s));
	sync_two_ff u_sda (.clk_sys(clk_sys), .rst(rst), .async_in(sda_in),
		.rst_val(1'b1), .sync_ff(sda_s));
	sync_two_ff u_pg (.clk_sys(clk_sys), .rst(rst), .async_in(power_good),
		.rst_val(1'b1), .sync_ff(pg_s));
	sync_two_ff u_txt (.clk_sys(clk_sys), .rst(rst),
		.async_in(transmit_threshold_pin), .rst_val(1'b1), .sync_ff(th_s));
	sync_two_ff u_rsel (.clk_sys(clk_sys), .rst(rst),
		.async_in(range_select_pin), .rst_val(1'b1), .sync_ff(rsel_s));
	sync_two_ff u_external_modulation_pin (.clk_sys(clk_sys), .rst(rst),
		.async_in(external_modulation_pin), .rst_val(1'b1),
		.sync_ff(external_modulation_pin_s));
	// Fault flags come from analog comparators, so they are synchronised
	genvar gi;
	wire [4:0] flt_raw = {over_temp_in, open_cable_in, voltage_range_in,
		overload_in, back_current_in};
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_flt
			sync_two_ff u_f (.clk_sys(clk_sys), .rst(rst),
				.async_in(flt_raw[gi]), .rst_val(1'b1),
				.sync_ff(flt_s[gi]));
		end
	endgenerate

	// ******************************
	// Line history and conditions
	// ******************************
	reg scl_d_ff;
	reg sda_d_ff;
	// Delayed copies for edge detection on synchronised lines
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end
	wire scl_rise = scl_s & ~scl_d_ff;
	wire scl_fall = ~scl_s & scl_d_ff;
	wire start_seen = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_seen = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	// ******************************
	// Protocol engine
	// ******************************
	reg [2:0] state_ff;
	reg [2:0] after_ack_ff;
	reg [3:0] bit_cnt_ff;
	reg [7:0] shift_ff;
	reg [4:0] tone_bits_ff;
	reg [4:0] cmd_bits_ff;
	reg [4:0] ctrl_bits_ff;
	reg [2:0] read_sel_ff;

	wire [6:0] my_addr = {`ADDR_FIXED, addr_pin_hi, addr_pin_lo};
	wire [7:0] next_byte = {shift_ff[6:0], sda_s};

	// Register image for reads; status carries selector bits zero
	reg [7:0] read_image;
	always @* begin
		case (read_sel_ff)
		`SEL_TONE_SETUP: read_image = {`SEL_TONE_SETUP, tone_bits_ff};
		`SEL_LIMIT_CMD: read_image = {`SEL_LIMIT_CMD, cmd_bits_ff};
		`SEL_OUTPUT_CTRL: read_image = {`SEL_OUTPUT_CTRL, ctrl_bits_ff};
		default: read_image = {`SEL_FAULT_STATUS, flt_s};
		endcase
	end

	// Bit engine sampling on clock rise, driving on clock fall
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			after_ack_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			sda_out_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			tone_bits_ff <= 5'h00;
			cmd_bits_ff <= 5'h00;
			ctrl_bits_ff <= 5'h00;
			read_sel_ff <= `SEL_FAULT_STATUS;
		end else if (!pg_s) begin
			state_ff <= ST_IDLE;
			sda_oe_ff <= 1'b0;
			tone_bits_ff <= 5'h00;
			cmd_bits_ff <= 5'h00;
			ctrl_bits_ff <= 5'h00;
			read_sel_ff <= `SEL_FAULT_STATUS;
		end else if (stop_seen) begin
			state_ff <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end else if (start_seen) begin
			state_ff <= ST_ADDR;
			bit_cnt_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
			ST_ADDR, ST_WDATA: begin
				if (scl_rise) begin
					shift_ff <= next_byte;
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				end else if (scl_fall && bit_cnt_ff == 4'h8) begin
					bit_cnt_ff <= 4'h0;
					if (state_ff == ST_ADDR) begin
						if (shift_ff[7:1] == my_addr) begin
							after_ack_ff <= shift_ff[0] ?
								ST_RDATA : ST_WDATA;
							state_ff <= ST_ACK;
							sda_out_ff <= 1'b0;
							sda_oe_ff <= 1'b1;
						end else begin
							state_ff <= ST_IGNORE;
						end
					end else begin
						if (shift_ff[7:5] == `SEL_TONE_SETUP) begin
							tone_bits_ff <= shift_ff[4:0] & `MASK_TONE;
						end else if (shift_ff[7:5] == `SEL_LIMIT_CMD) begin
							cmd_bits_ff <= shift_ff[4:0] & `MASK_CMD;
						end else if (shift_ff[7:5] == `SEL_OUTPUT_CTRL) begin
							ctrl_bits_ff <= shift_ff[4:0] & `MASK_CTRL;
						end
						if (shift_ff[7:5] <= `SEL_OUTPUT_CTRL) begin
							read_sel_ff <= shift_ff[7:5];
						end
						after_ack_ff <= ST_WDATA;
						state_ff <= ST_ACK;
						sda_out_ff <= 1'b0;
						sda_oe_ff <= 1'b1;
					end
				end
			end
			ST_ACK: begin
				// Release at end of ninth pulse
				if (scl_fall) begin
					state_ff <= after_ack_ff;
					bit_cnt_ff <= 4'h0;
					if (after_ack_ff == ST_RDATA) begin
						shift_ff <= {read_image[6:0], 1'b0};
						sda_out_ff <= 1'b0;
						sda_oe_ff <= ~read_image[7];
					end else begin
						sda_oe_ff <= 1'b0;
					end
				end
			end
			ST_RDATA: begin
				// change data only after clock falls
				if (scl_fall) begin
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
					if (bit_cnt_ff == 4'h7) begin
						sda_oe_ff <= 1'b0;
						state_ff <= ST_RACK;
					end else begin
						sda_oe_ff <= ~shift_ff[7];
						shift_ff <= {shift_ff[6:0], 1'b0};
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					after_ack_ff <= sda_s ? ST_IGNORE : ST_RDATA;
				end else if (scl_fall) begin
					state_ff <= after_ack_ff;
					bit_cnt_ff <= 4'h0;
					if (after_ack_ff == ST_RDATA) begin
						shift_ff <= {read_image[6:0], 1'b0};
						sda_oe_ff <= ~read_image[7];
					end
				end
			end
			default: begin
				sda_oe_ff <= 1'b0;
			end
			endcase
		end
	end

	// ******************************
	// Decoded outputs
	// ******************************
	reg nxt_tone_on;
	always @* begin
		if (tone_bits_ff[`BIT_TONE_ENABLE] &&
			!tone_bits_ff[`BIT_MOD_SELECT]) begin
			nxt_tone_on = 1'b1;
		end else if (!tone_bits_ff[`BIT_TONE_ENABLE] &&
			!tone_bits_ff[`BIT_MOD_SELECT]) begin
			nxt_tone_on = external_modulation_pin_s;
		end else begin
			nxt_tone_on = 1'b0;
		end
	end

	// Registered outputs toward the analog blocks
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tone_on_ff <= 1'b0;
			tone_passthru_ff <= 1'b0;
			tone_threshold_ff <= 1'b0;
			limit_mode_static_ff <= 1'b0;
			current_level_ff <= 2'h0;
			output_enable_ff <= 1'b0;
			voltage_level_ff <= 2'h0;
			fault_status_ff <= `REG_RESET;
		end else begin
			tone_on_ff <= nxt_tone_on;
			tone_passthru_ff <= ~tone_bits_ff[`BIT_TONE_ENABLE] &
				tone_bits_ff[`BIT_MOD_SELECT];
			// threshold is OR of bit and pin
			tone_threshold_ff <= tone_bits_ff[`BIT_TONE_THRESH] | th_s;
			limit_mode_static_ff <= cmd_bits_ff[`BIT_LIMIT_STATIC];
			current_level_ff <= cmd_bits_ff[1:0];
			output_enable_ff <= ctrl_bits_ff[`BIT_OUT_ENABLE];
			if (cmd_bits_ff[`BIT_VPIN_ENABLE]) begin
				voltage_level_ff <= ctrl_bits_ff[1:0];
			end else begin
				voltage_level_ff <= {rsel_s, rsel_s ? ctrl_bits_ff[1] :
					ctrl_bits_ff[0]};
			end
			fault_status_ff <= {`SEL_FAULT_STATUS, flt_s};
		end
	end
endmodule // lnb_regulator_i2c_registers

// File: core/sync_two_ff.v
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module sync_two_ff (
	input wire clk_sys,
	input wire rst,
	input wire async_in,
	input wire rst_val,
	output reg sync_ff
);
	reg meta_ff;

	// Only the second stage is read outside
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end
	wire unused_rst_val = rst_val;
endmodule // sync_two_ff

// File: tb/host_model.sv
// Behavioural two-wire bus master driving clock and data
`timescale 1ns/1ps
module host_model #(parameter int QP = 100) (
	output logic scl,
	output logic sda_low,
	input wire sda
);
	// ****
	// Bus cycles
	// ****
	// Both lines released; pull-ups give idle high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// open drain, data moves while clock low
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#QP scl = 1'b1;
		#QP r = sda;
		#QP scl = 1'b0;
		#QP;
	endtask
	// eight bits msb first plus acknowledge
	task automatic byte_io(input logic [7:0] wb, input logic ab,
		output logic [7:0] rb, output logic ak);
		for (int i = 7; i >= 0; i--)
			bit_io(wb[i], rb[i]);
		bit_io(ab, ak);
	endtask
	// every frame opens with start and closes with stop
	task automatic xfer(input logic [7:0] adr, input logic [7:0] wb,
		output logic [15:0] rb, output logic [1:0] ak);
		logic a;
		rb = 16'h0000;
		ak = 2'b11;
		sda_low = 1'b1;
		#QP scl = 1'b0;
		#QP;
		byte_io(adr, 1'b1, rb[15:8], ak[1]);
		// refused address ends the frame at once
		if (ak[1] == 1'b0) begin
			// acknowledge first read byte, refuse the last
			if (adr[0]) begin
				byte_io(8'hFF, 1'b0, rb[15:8], a);
				byte_io(8'hFF, 1'b1, rb[7:0], a);
			end else
				byte_io(wb, 1'b1, rb[7:0], ak[0]);
		end
		sda_low = 1'b1;
		#QP scl = 1'b1;
		#QP sda_low = 1'b0;
		#(2 * QP);
	endtask
endmodule // host_model

// File: tb/lnb_regs_asserts.sv
// Port-level checks for the regulator register interface
`timescale 1ns/1ps
module lnb_regs_asserts (
	input wire clk_sys,
	input wire rst,
	input wire scl_in,
	input wire sda_out_ff,
	input wire sda_oe_ff,
	input wire power_good,
	input wire over_temp_in,
	input wire open_cable_in,
	input wire voltage_range_in,
	input wire overload_in,
	input wire back_current_in,
	input wire tone_on_ff,
	input wire tone_passthru_ff,
	input wire limit_mode_static_ff,
	input wire [1:0] current_level_ff,
	input wire output_enable_ff,
	input wire [7:0] fault_status_ff
);
	// ****
	// Sequences
	// ****
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire [4:0] flags = {over_temp_in, open_cable_in, voltage_range_in,
		overload_in, back_current_in};
	// Flags settle only after sync and register stages
	sequence flags_steady;
		(power_good && $stable(flags))[*5];
	endsequence
	sequence pg_off;
		!power_good[*5];
	endsequence
	sequence ack_on;
		$rose(sda_oe_ff);
	endsequence
	oe_drive_low_a: assert property (sda_oe_ff |-> !sda_out_ff)
		else $error("data line driven high");
	oe_edge_low_a: assert property ($changed(sda_oe_ff) |-> !scl_in)
		else $error("data drive changed while clock high");
	ack_hold_a: assert property (ack_on |-> sda_oe_ff[*8])
		else $error("acknowledge pulse too short");
	pg_quiet_a: assert property (pg_off |-> !sda_oe_ff)
		else $error("drive while power-good low");
	pg_clear_a: assert property (pg_off |-> !(limit_mode_static_ff ||
		output_enable_ff || tone_passthru_ff) && current_level_ff == 2'b00)
		else $error("config kept while power-good low");
	reset_zero_a: assert property ($fell(rst) |->
		fault_status_ff == 8'h00 && !output_enable_ff && !sda_oe_ff)
		else $error("nonzero state after reset");
	fault_map_a: assert property (flags_steady |->
		fault_status_ff == {3'b000, flags})
		else $error("status flags differ from inputs");
	spare_zero_a: assert property (fault_status_ff[7:5] == 3'b000)
		else $error("status spare bits set");
	tone_excl_a: assert property (!(tone_on_ff && tone_passthru_ff))
		else $error("two tone sources at once");
endmodule // lnb_regs_asserts

// File: tb/tb_top.sv
// Self-checking bench for the regulator register interface
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic power_good = 1'b1;
	logic [1:0] adp = 2'b00;
	logic [2:0] pins = 3'b000;
	logic [4:0] flt = 5'h00;
	logic scl, sda_low, sda_out_ff, sda_oe_ff, ton, tpt, tone_threshold, lst, oen;
	logic [1:0] cur, vlt;
	logic [7:0] fst;
	logic [15:0] rb;
	logic [1:0] ak;
	int n_fail = 0;
	int num_checks = 0;
	// Wired-AND data line with pull-up
	wire sda = !(sda_low || sda_oe_ff);
	wire [8:0] vec = {ton, tpt, tone_threshold, lst, cur, oen, vlt};
	// Write byte, read-back byte, expected outputs after the write
	logic [24:0] rows [10] = '{{8'h30, 8'h30, 9'h100},
		{8'h2C, 8'h2C, 9'h0C0}, {8'h5B, 8'h5B, 9'h0F8},
		{8'h7F, 8'h73, 9'h0FF}, {8'h63, 8'h63, 9'h0FB},
		{8'h41, 8'h41, 9'h0C9}, {8'h42, 8'h42, 9'h0D1},
		{8'h20, 8'h20, 9'h011}, {8'h1F, 8'h0A, 9'h011},
		{8'hFF, 8'h0A, 9'h011}};
	always #25 clk_sys = !clk_sys;
	lnb_regulator_i2c_registers dut_u (.clk_sys(clk_sys), .rst(rst),
		.scl_in(scl), .sda_in(sda), .sda_out_ff(sda_out_ff),
		.sda_oe_ff(sda_oe_ff), .power_good(power_good),
		.addr_pin_hi(adp[1]), .addr_pin_lo(adp[0]),
		.range_select_pin(pins[2]), .external_modulation_pin(pins[1]),
		.transmit_threshold_pin(pins[0]), .over_temp_in(flt[4]),
		.open_cable_in(flt[3]), .voltage_range_in(flt[2]),
		.overload_in(flt[1]), .back_current_in(flt[0]),
		.tone_on_ff(ton), .tone_passthru_ff(tpt), .tone_threshold_ff(tone_threshold),
		.limit_mode_static_ff(lst), .current_level_ff(cur),
		.output_enable_ff(oen), .voltage_level_ff(vlt),
		.fault_status_ff(fst));
	// Link clock of 400 ns; quarter steps land on falling clock edges
	host_model #(.QP(100)) host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard, well past the expected run
	initial begin
		#1_000_000;
		n_fail++;
		report_and_stop();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		repeat (8) @(negedge clk_sys);
		check("reset outputs", 16'h0000, {7'h00, vec});
		host_u.xfer(8'h11, 8'hFF, rb, ak);
		check("reset read", 16'h0000, rb);
		@(negedge clk_sys);
		flt = 5'h0A;
		foreach (rows[i]) begin
			host_u.xfer(8'h10, rows[i][24:17], rb, ak);
			check("write ack", 16'h0000, {14'h0000, ak});
			host_u.xfer(8'h11, 8'hFF, rb, ak);
			check("read data", {2{rows[i][16:9]}}, rb);
			@(negedge clk_sys);
			check("outputs", {7'h00, rows[i][8:0]}, {7'h00, vec});
			check("status", {11'h000, flt}, {8'h00, fst});
		end
		pins = 3'b111;
		repeat (8) @(negedge clk_sys);
		check("pin overrides", 16'h0153, {7'h00, vec});
		pins = 3'b000;
		for (int p = 0; p < 4; p++) begin
			@(negedge clk_sys);
			adp = p[1:0];
			host_u.xfer({5'h02, adp ^ 2'b01, 1'b0}, 8'h2C, rb, ak);
			check("foreign address", 16'h0003, {14'h0000, ak});
			host_u.xfer({5'h02, adp, 1'b0}, 8'h30, rb, ak);
			check("own address", 16'h0000, {14'h0000, ak});
		end
		@(negedge clk_sys);
		check("after strap sweep", 16'h0111, {7'h00, vec});
		power_good = 1'b0;
		repeat (8) @(negedge clk_sys);
		check("cleared outputs", 16'h0000, {7'h00, vec});
		host_u.xfer(8'h16, 8'h5B, rb, ak);
		check("unpowered ack", 16'h0003, {14'h0000, ak});
		@(negedge clk_sys);
		power_good = 1'b1;
		flt = 5'h15;
		repeat (8) @(negedge clk_sys);
		check("config after power-up", 16'h0000, {7'h00, vec});
		host_u.xfer(8'h17, 8'hFF, rb, ak);
		check("fault byte", 16'h1515, rb);
		report_and_stop();
	end
endmodule // tb_top
bind lnb_regulator_i2c_registers lnb_regs_asserts chk_u (.clk_sys(clk_sys),
	.rst(rst), .scl_in(scl_in), .sda_out_ff(sda_out_ff),
	.sda_oe_ff(sda_oe_ff), .power_good(power_good),
	.over_temp_in(over_temp_in), .open_cable_in(open_cable_in),
	.voltage_range_in(voltage_range_in), .overload_in(overload_in),
	.back_current_in(back_current_in), .tone_on_ff(tone_on_ff),
	.tone_passthru_ff(tone_passthru_ff),
	.limit_mode_static_ff(limit_mode_static_ff),
	.current_level_ff(current_level_ff),
	.output_enable_ff(output_enable_ff), .fault_status_ff(fault_status_ff));
